// ---- design/dag_drive_angle_select.sv ----
/*
 Drive angle selection for a sinusoidal three-phase commutator.
 Assumes pad comparators give Hall bits and three-level pin codes,
 and a current-zero-crossing comparator on phase U.
*/
`timescale 1ns/1ps
module dag_drive_angle_select (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // Three-level configuration pins, decoded by pads
   input wire logic [1:0] i_commutation_mode_pin,
   input wire logic [1:0] i_drive_angle_pin,
   // Hall comparator pairs
   input wire logic [2:0] i_hall_positive_input,
   input wire logic [2:0] i_hall_negative_input,
   // Phase U current polarity (high = positive)
   input wire logic i_u_current_pos,
   // Outputs
   output logic [2:0] o_hall_channel_bit,
   output logic o_commutation_hall_u,
   output dag_pkg::dag_drive_t o_drive
);
   typedef enum logic [1:0] {
      DAG_ST_LATCH = 2'b00,
      DAG_ST_START = 2'b01,
      DAG_ST_SINE  = 2'b10
   } dag_state_t;

   logic [2:0] cmp;
   logic [2:0] hall_f;
   dag_state_t state_reg, state_next;
   dag_pkg::dag_mode_t mode_reg, mode_next;
   dag_pkg::dag_level_t angle_pin_reg, angle_pin_next;
   logic [2:0] cyc_reg, cyc_next;
   logic hu_d_reg, hu_d_next;
   logic [2:0] cur_sync_reg, cur_sync_next;
   logic cur_d_reg, cur_d_next;
   logic cur_seen_reg, cur_seen_next;
   logic [7:0] adapt_reg, adapt_next;
   logic [2:0] hall_out_reg;
   logic hu_out_reg;
   dag_pkg::dag_drive_t drive_reg, drive_next;
   logic hu_rise, cur_rise;
   logic [7:0] fixed_ang;
   logic [3:0] cfg_s0_reg, cfg_s0_next;
   logic [3:0] cfg_s1_reg, cfg_s1_next;
   logic [3:0] cfg_s2_reg, cfg_s2_next;
   logic [1:0] fill_reg, fill_next;
   logic cfg_agree;
   logic [2:0] hall_out_next;
   logic hu_out_next;

   assign cmp = i_hall_positive_input & ~i_hall_negative_input;

   for (genvar g = 0; g < 3; g++) begin : g_hall
      dag_hall_filter u_filt (
         .i_mclk(i_mclk),
         .i_rst(i_rst),
         .i_cmp(cmp[g]),
         .o_level(hall_f[g])
      );
   end

   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      angle_pin_next = angle_pin_reg;
      cyc_next = cyc_reg;
      hu_d_next = hall_f[2];
      cur_sync_next = {cur_sync_reg[1:0], i_u_current_pos};
      // Agreed level only, so a lone flop glitch cannot fake an edge
      cur_d_next = (cur_sync_reg[2] == cur_sync_reg[1]) ? cur_sync_reg[2] : cur_d_reg;
      cur_seen_next = cur_seen_reg;
      adapt_next = adapt_reg;
      hu_rise = hall_f[2] & ~hu_d_reg;
      cur_rise = (cur_sync_reg[2] == cur_sync_reg[1]) & cur_sync_reg[2] & ~cur_d_reg;
      unique case (state_reg)
         DAG_ST_LATCH: begin
            // One-shot capture; later pad moves are ignored until reset
            if (cfg_agree) begin
               mode_next = (cfg_s2_reg[3:2] == dag_pkg::DAG_LVL_GND) ?
                  dag_pkg::DAG_MODE_SIN0 : (cfg_s2_reg[3:2] == dag_pkg::DAG_LVL_RAIL) ?
                  dag_pkg::DAG_MODE_SIN30 : dag_pkg::DAG_MODE_TRAP;
               angle_pin_next = dag_pkg::dag_level_t'(cfg_s2_reg[1:0]);
               cyc_next = 3'h0;
               state_next = DAG_ST_START;
            end
         end
         DAG_ST_START: begin
            // Stays here for trapezoidal mode forever
            if (mode_reg != dag_pkg::DAG_MODE_TRAP && hu_rise) begin
               if (cyc_reg == dag_pkg::DAG_START_CYCLES - 3'h1) begin
                  state_next = DAG_ST_SINE;
               end
               cyc_next = cyc_reg + 3'h1;
            end
         end
         DAG_ST_SINE: begin
            // Current lag past Hall edge: advance; early current: retard
            if (hu_rise) begin
               cur_seen_next = 1'b0;
            end
            if (cur_rise) begin
               cur_seen_next = 1'b1;
            end
            if (drive_reg.adaptive && hu_rise) begin
               if (!cur_seen_reg && adapt_reg != dag_pkg::DAG_ANG_MAX) begin
                  adapt_next = adapt_reg + 8'h01;
               end else if (cur_seen_reg && adapt_reg != dag_pkg::DAG_ANG_0) begin
                  adapt_next = adapt_reg - 8'h01;
               end
            end
         end
         default: state_next = DAG_ST_LATCH;
      endcase
   end

   always_comb begin
      unique case (angle_pin_reg)
         dag_pkg::DAG_LVL_GND: fixed_ang = dag_pkg::DAG_ANG_10;
         dag_pkg::DAG_LVL_RAIL: fixed_ang = dag_pkg::DAG_ANG_5;
         default: fixed_ang = dag_pkg::DAG_ANG_0;
      endcase
      hall_out_next = hall_f;
      hu_out_next = hall_f[2];
      drive_next.mode = mode_reg;
      drive_next.sin_active = (state_reg == DAG_ST_SINE);
      drive_next.adaptive = (mode_reg == dag_pkg::DAG_MODE_SIN0) &&
         (angle_pin_reg == dag_pkg::DAG_LVL_FLOAT);
      if (mode_reg == dag_pkg::DAG_MODE_TRAP) begin
         drive_next.angle_bemf = dag_pkg::DAG_ANG_0;
         drive_next.angle_hall = dag_pkg::DAG_ANG_0;
      end else if (drive_next.adaptive) begin
         drive_next.angle_bemf = adapt_reg;
         drive_next.angle_hall = adapt_reg;
      end else if (mode_reg == dag_pkg::DAG_MODE_SIN30) begin
         drive_next.angle_bemf = fixed_ang;
         drive_next.angle_hall = fixed_ang + dag_pkg::DAG_ANG_30;
      end else begin
         drive_next.angle_bemf = fixed_ang;
         drive_next.angle_hall = fixed_ang;
      end
   end

   // Config pads: three flops, taken once the last two agree
   always_comb begin
      cfg_s0_next = {i_commutation_mode_pin, i_drive_angle_pin};
      cfg_s1_next = cfg_s0_reg;
      cfg_s2_next = cfg_s1_reg;
      fill_next = fill_reg;
      if (state_reg == DAG_ST_LATCH && fill_reg != 2'(dag_pkg::DAG_SYNC_STAGES)) begin
         fill_next = fill_reg + 2'h1;
      end
      // Waiting for a full pipe keeps the reset zeros from being latched
      cfg_agree = (fill_reg == 2'(dag_pkg::DAG_SYNC_STAGES)) && (cfg_s2_reg == cfg_s1_reg);
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cfg_s0_reg <= 4'h0;
         cfg_s1_reg <= 4'h0;
         cfg_s2_reg <= 4'h0;
         fill_reg <= 2'h0;
      end else begin
         cfg_s0_reg <= cfg_s0_next;
         cfg_s1_reg <= cfg_s1_next;
         cfg_s2_reg <= cfg_s2_next;
         fill_reg <= fill_next;
      end
   end

   // Mode and startup state
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= DAG_ST_LATCH;
         mode_reg <= dag_pkg::DAG_MODE_TRAP;
         angle_pin_reg <= dag_pkg::DAG_LVL_FLOAT;
         cyc_reg <= 3'h0;
      end else begin
         state_reg <= state_next;
         mode_reg <= mode_next;
         angle_pin_reg <= angle_pin_next;
         cyc_reg <= cyc_next;
      end
   end

   // Edge tracking and adaptive angle
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         hu_d_reg <= 1'b0;
         cur_sync_reg <= 3'h0;
         cur_d_reg <= 1'b0;
         cur_seen_reg <= 1'b0;
         adapt_reg <= dag_pkg::DAG_ANG_RST;
      end else begin
         hu_d_reg <= hu_d_next;
         cur_sync_reg <= cur_sync_next;
         cur_d_reg <= cur_d_next;
         cur_seen_reg <= cur_seen_next;
         adapt_reg <= adapt_next;
      end
   end

   // Output registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         hall_out_reg <= 3'h0;
         hu_out_reg <= 1'b0;
         drive_reg <= '0;
      end else begin
         hall_out_reg <= hall_out_next;
         hu_out_reg <= hu_out_next;
         drive_reg <= drive_next;
      end
   end

   assign o_hall_channel_bit = hall_out_reg;
   assign o_commutation_hall_u = hu_out_reg;
   assign o_drive = drive_reg;
endmodule // dag_drive_angle_select

// ---- shared/dag_pkg.sv ----
/*
 Package for the drive angle select block: pin level codes, modes,
 angle codes, filter and startup timing constants, carrier structs.
 Assumes a 20 MHz core clock.
*/
package dag_pkg;

   // Three-level pin as seen by the pad comparators
   typedef enum logic [1:0] {
      DAG_LVL_FLOAT = 2'b00,
      DAG_LVL_GND   = 2'b01,
      DAG_LVL_RAIL  = 2'b10
   } dag_level_t;

   typedef enum logic [1:0] {
      DAG_MODE_TRAP  = 2'b00,
      DAG_MODE_SIN0  = 2'b01,
      DAG_MODE_SIN30 = 2'b10
   } dag_mode_t;

   // Angle unit is one electrical degree
   localparam int DAG_ANG_W = 8;
   localparam logic [7:0] DAG_ANG_0 = 8'h00;
   localparam logic [7:0] DAG_ANG_5 = 8'h05;
   localparam logic [7:0] DAG_ANG_10 = 8'h0A;
   localparam logic [7:0] DAG_ANG_30 = 8'h1E;
   localparam logic [7:0] DAG_ANG_MAX = 8'h3C;
   localparam logic [7:0] DAG_ANG_RST = 8'h00;

   localparam int DAG_CLK_HZ = 20000000;
   localparam int DAG_FILT_US = 320;
   localparam int DAG_FILT_CYC = (DAG_FILT_US * (DAG_CLK_HZ / 1000000));
   localparam int DAG_FILT_W = 13;
   localparam logic [2:0] DAG_START_CYCLES = 3'h6;
   localparam int DAG_SYNC_STAGES = 3;

   typedef struct packed {
      logic u;
      logic v;
      logic w;
   } dag_hall_t;

   typedef struct packed {
      dag_mode_t mode;
      logic adaptive;
      logic sin_active;
      logic [7:0] angle_bemf;
      logic [7:0] angle_hall;
   } dag_drive_t;

endpackage

// ---- design/dag_hall_filter.sv ----
/*
 One Hall channel: 3-flop synchroniser of the comparator output,
 then a fixed-time filter. Assumes i_cmp is asynchronous.
*/
`timescale 1ns/1ps
module dag_hall_filter (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // Comparator result
   input wire logic i_cmp,
   // Filtered level
   output logic o_level
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic [12:0] cnt_reg;
   logic [12:0] cnt_next;
   logic level_reg;
   logic level_next;

   always_comb begin
      sync_next = {sync_reg[1:0], i_cmp};
      cnt_next = cnt_reg;
      level_next = level_reg;
      // Stages 1 and 2 agree: stage 0 is never read here
      if (sync_reg[2] != sync_reg[1] || sync_reg[1] == level_reg) begin
         cnt_next = 13'h0000;
      end else if (cnt_reg == 13'(dag_pkg::DAG_FILT_CYC - 1)) begin
         level_next = sync_reg[1];
         cnt_next = 13'h0000;
      end else begin
         cnt_next = cnt_reg + 13'h0001;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sync_reg <= 3'h0;
         cnt_reg <= 13'h0000;
         level_reg <= 1'b0;
      end else begin
         sync_reg <= sync_next;
         cnt_reg <= cnt_next;
         level_reg <= level_next;
      end
   end

   assign o_level = level_reg;
endmodule // dag_hall_filter

// ---- tb/dag_sva.sv ----
/* Checker for the drive angle select outputs.
 Assumes it is bound onto the top module and sees only its ports. */
`timescale 1ns/1ps
module dag_sva (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // Watched ports
   input wire logic [2:0] i_hall_positive_input,
   input wire logic [2:0] i_hall_negative_input,
   input wire logic [2:0] o_hall_channel_bit,
   input wire logic o_commutation_hall_u,
   input wire dag_pkg::dag_drive_t o_drive
);
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic u_in;
   logic up;
   logic u_d_reg;
   logic u_d_next;
   logic [13:0] stab_reg;
   logic [13:0] stab_next;
   assign u_in = i_hall_positive_input[2] & ~i_hall_negative_input[2];
   // Settled once the synchronised, latched modes have reached the outputs
   assign up = (cnt_reg == 3'h7);
   always_comb begin
      cnt_next = up ? cnt_reg : cnt_reg + 3'h1;
      u_d_next = u_in;
      // Cycles the raw U level has held, saturating
      stab_next = (u_in != u_d_reg) ? 14'h0000 :
         (stab_reg == 14'h3FFF) ? stab_reg : stab_reg + 14'h0001;
   end
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cnt_reg <= 3'h0;
         u_d_reg <= 1'b0;
         stab_reg <= 14'h0000;
      end else begin
         cnt_reg <= cnt_next;
         u_d_reg <= u_d_next;
         stab_reg <= stab_next;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   sequence s_u_edge;
      $changed(o_commutation_hall_u);
   endsequence
   a_mode_held: assert property (up |-> $stable(o_drive.mode))
      else $error("mode moved after latch");
   a_trap_plain: assert property (up && o_drive.mode == 2'h0 |->
      o_drive.angle_bemf == 8'h00 && o_drive.angle_hall == 8'h00 &&
      !o_drive.adaptive && !o_drive.sin_active)
      else $error("trapezoidal mode uses angle");
   a_adapt_sin0: assert property (o_drive.adaptive |-> o_drive.mode == 2'h1)
      else $error("adaptive outside sin0");
   a_sin30_offset: assert property (up && o_drive.mode == 2'h2 |->
      o_drive.angle_hall == o_drive.angle_bemf + 8'h1E)
      else $error("hall angle offset wrong");
   a_sin0_ref: assert property (up && o_drive.mode == 2'h1 |->
      o_drive.angle_hall == o_drive.angle_bemf)
      else $error("sin0 reference wrong");
   a_u_only: assert property (o_hall_channel_bit[2] == o_commutation_hall_u)
      else $error("commutation bit differs");
   a_filter_age: assert property (s_u_edge |->
      u_in == o_commutation_hall_u && stab_reg >= 14'(dag_pkg::DAG_FILT_CYC) &&
      stab_reg <= 14'(dag_pkg::DAG_FILT_CYC + 8))
      else $error("hall edge not filtered");
   a_angle_step: assert property (up && o_drive.adaptive && $changed(o_drive.angle_bemf) |->
      ($past(o_drive.angle_bemf) + 8'h01 == o_drive.angle_bemf) ||
      (o_drive.angle_bemf + 8'h01 == $past(o_drive.angle_bemf)))
      else $error("adaptive step wrong");
endmodule // dag_sva
bind dag_drive_angle_select dag_sva u_sva (.i_mclk(i_mclk), .i_rst(i_rst),
   .i_hall_positive_input(i_hall_positive_input), .i_hall_negative_input(i_hall_negative_input),
   .o_hall_channel_bit(o_hall_channel_bit), .o_commutation_hall_u(o_commutation_hall_u),
   .o_drive(o_drive));

// ---- tb/dag_motor_model.sv ----
/* Motor model: differential Hall pairs and U current sign.
 Assumes the bench picks the rotor sector. */
`timescale 1ns/1ps
module dag_motor_model (
   // Rotor state
   input wire logic [2:0] i_sector,
   input wire logic i_cur,
   // Hall pairs and current sign
   output logic [2:0] o_pos,
   output logic [2:0] o_neg,
   output logic o_cur
);
   // Hall element legs swing in opposition
   assign o_pos = i_sector;
   assign o_neg = ~i_sector;
   assign o_cur = i_cur;
endmodule // dag_motor_model

// ---- tb/testbench.sv ----
/* Bench: pin decode table, Hall filter timing, startup handover.
 Assumes the motor model and a 20 MHz clock. */
`timescale 1ns/1ps
module testbench;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [1:0] cm = 2'h0;
   logic [1:0] da = 2'h0;
   logic [2:0] sec = 3'h1;
   logic cur = 1'b0;
   logic [2:0] pos;
   logic [2:0] neg;
   logic [2:0] hb;
   logic u_cur;
   logic hu;
   dag_pkg::dag_drive_t drv;
   int num_errors = 0;
   int check_count = 0;
   always #25 i_mclk = ~i_mclk;
   dag_motor_model motor (.i_sector(sec), .i_cur(cur), .o_pos(pos), .o_neg(neg), .o_cur(u_cur));
   dag_drive_angle_select uut (.i_mclk(i_mclk), .i_rst(i_rst), .i_commutation_mode_pin(cm),
      .i_drive_angle_pin(da), .i_hall_positive_input(pos), .i_hall_negative_input(neg),
      .i_u_current_pos(u_cur), .o_hall_channel_bit(hb), .o_commutation_hall_u(hu),
      .o_drive(drv));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic start(input logic [1:0] m, input logic [1:0] a);
      logic [7:0] eb;
      eb = (m == 2'h0 || a == 2'h0) ? 8'h00 : (a == 2'h1) ? 8'h0A : 8'h05;
      @(posedge i_mclk);
      i_rst <= 1'b1;
      cm <= m;
      da <= a;
      repeat (5) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (6) @(posedge i_mclk);
      // Pins moved after latching must not reach the outputs
      cm <= m + 2'h1;
      da <= a + 2'h1;
      repeat (3) @(posedge i_mclk);
      #1;
      chk(drv, {m, m == 2'h1 && a == 2'h0, 1'b0, eb, eb + ((m == 2'h2) ? 8'h1E : 8'h00)});
   endtask
   // Counts cycles until the filtered U bit reaches e
   task automatic wait_u(input logic e);
      int n;
      n = 0;
      while (hu !== e && n < 7000) begin
         @(posedge i_mclk);
         #1;
         n++;
      end
      chk(n >= 6395 && n <= 6415, 1);
      if (n >= 7000) begin
         results();
      end
   endtask
   initial begin
      int k;
      int r;
      int ang;
      int v;
      int cur_q[$];
      r = $urandom(32'h92AC);
      for (k = 0; k < 9; k++) begin
         start(2'(k / 3), 2'(k % 3));
      end
      $display("decode test done");
      start(2'h1, 2'h0);
      repeat (6600) @(posedge i_mclk);
      #1;
      chk(hb, 3'h1);
      @(posedge i_mclk);
      sec <= 3'h3;
      // Glitch on V shorter than the filter time
      repeat (r % 1000 + 10) @(posedge i_mclk);
      ang = 0;
      cur_q.push_back(0);
      // Seven Hall cycles: six for startup, then one adaptive step
      for (k = 1; k <= 7; k++) begin
         // Current held low in the last cycle so the angle must advance
         v = (k == 7) ? 0 : int'($urandom % 2);
         sec <= 3'h4;
         cur <= 1'(v);
         wait_u(1'b1);
         chk(hb, 3'h4);
         // Model: a current rise since the last Hall rise retards the angle
         if (k > 6 && cur_q[$] == 0 && v == 1) begin
            ang = (ang > 0) ? ang - 1 : 0;
         end else if (k > 6) begin
            ang = (ang < int'(dag_pkg::DAG_ANG_MAX)) ? ang + 1 : ang;
         end
         cur_q.push_back(v);
         repeat (4) @(posedge i_mclk);
         #1;
         chk(drv.sin_active, k >= 6);
         chk(drv.angle_bemf, ang);
         chk(drv.angle_hall, ang);
         @(posedge i_mclk);
         sec <= 3'h1;
         wait_u(1'b0);
         @(posedge i_mclk);
      end
      $display("hall test done");
      results();
   end
endmodule // testbench
